// File: pls_pkg.sv
package pls_pkg;

    // ------------------------------------------------------------------
    // Encodings and constants
    // ------------------------------------------------------------------
    localparam logic [5:0]  SYNDROME_SYSREG   = 6'h18;
    localparam logic [15:0] DEFER_SLOT_OFFSET = 16'h0900;
    localparam logic [2:0]  NV_TRIPLE_ALIAS   = 3'h5;
    localparam logic [2:0]  NV_TRIPLE_EL1     = 3'h7;

    localparam int          ENABLE_BIT        = 63;
    localparam int          TRAP_EL0_BIT      = 49;
    localparam int          TRAP_EL1_BIT      = 48;
    localparam int          FIELD_MSB         = 47;
    localparam int          PMG_D_LSB         = 40;
    localparam int          PMG_I_LSB         = 32;
    localparam int          PARTITION_ID_D_LSB      = 16;
    localparam int          PARTITION_ID_I_LSB      = 0;

    localparam logic        RST_ENABLE        = 1'h0;
    localparam logic [47:0] RST_FIELDS        = 48'h0000_0000_0000;
    localparam logic        RST_TRAP_NO_EL3   = 1'h1;
    localparam logic        RST_TRAP_WITH_EL3 = 1'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PLS_EL0,
        PLS_EL1,
        PLS_EL2,
        PLS_EL3
    } pls_el_type;

    typedef enum logic [1:0] {
        PLS_SEL_EL1_LABEL,
        PLS_SEL_EL1_ALIAS_UPPER,
        PLS_SEL_EL2_LABEL,
        PLS_SEL_NONE
    } pls_sel_type;

    typedef enum logic [2:0] {
        PLS_RESP_DONE,
        PLS_RESP_UNDEF,
        PLS_RESP_TRAP_EL2,
        PLS_RESP_TRAP_EL3,
        PLS_RESP_DEFER
    } pls_resp_kind_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        pls_sel_type sel;
        pls_el_type  el;
        logic [63:0] wdata;
    } pls_req_type;

    typedef struct packed {
        logic el2_enabled;
        logic el2_is_64bit;
        logic host_extension_mode;
        logic nested_virt_bit;
        logic nested_virt_bit1;
        logic nested_virt_bit2;
        logic lower_level_trap;
        logic el3_label_enable;
        logic halted;
        logic secure_debug_disable;
    } pls_cfg_type;

    typedef struct packed {
        logic              valid;
        pls_resp_kind_type kind;
        logic [5:0]        syndrome;
        logic [63:0]       rdata;
        logic [15:0]       defer_offset;
        logic              defer_write;
        logic [63:0]       defer_wdata;
    } pls_resp_type;

    typedef struct packed {
        logic       valid;
        pls_el_type el;
        logic       instr;
    } pls_mreq_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] partition_id;
        logic [7:0]  monitor_group;
    } pls_label_type;

endpackage : pls_pkg

// File: pls_sysreg_access.sv
`timescale 1ns/1ps
// Summary of operation
// - Label register or upper alias access from EL0 is undefined.
// - EL1 alias access with triple 101 goes to deferred slot 0x900.
// - Other EL1 alias accesses trap 0x18 to EL3 or EL2 if nested; else undefined.
// - EL2 alias access reaches EL1 register only with host extension mode set.
// - EL3 alias access needs EL2 enabled, 64-bit EL2 and host extension mode.
// - Lower-level trap sends EL1/EL2 accesses to EL3, class 0x18; first only for EL1 register access and EL2 register at EL2.
// - An EL3 trap while halted with secure debug disable becomes undefined.
// - Untrapped, unredirected EL1 write stores source bits 47..0 in EL1 register.
// - EL1 access with EL2 trap bit set traps to EL2, class 0x18.
// - EL1 access with triple 111 goes to deferred slot 0x900.
// - EL2 register is 64 bits and labels requests made at EL2.
// - EL2 register does not label anything while EL2 is disabled.
// - Enable bit 63 is one bit shared by EL1, EL2 and EL3 registers.
// - Enable low gives default identifiers; high uses the EL1 register at EL0/EL1, the EL2 register at EL2, defaults at EL3.
// - Enable in EL2 register writable without EL3, else mirrors EL3 bit.
// - Warm reset clears the enable bit.
module pls_sysreg_access #(
    parameter bit          HAS_EL3        = 1'b1,
    parameter logic [15:0] DEFAULT_PARTITION_ID = 16'h0000,
    parameter logic [7:0]  DEFAULT_PMG    = 8'h00
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire pls_pkg::pls_req_type   req,
    input  wire pls_pkg::pls_cfg_type   cfg,
    input  wire pls_pkg::pls_mreq_type  mreq,
    output pls_pkg::pls_resp_type       resp,
    output pls_pkg::pls_label_type      label,
    output logic                        label_enable
);
    import pls_pkg::*;

    // ------------------------------------------------------------------
    // Access decisions
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ACT_UNDEF,
        ACT_TRAP_EL2,
        ACT_TRAP_EL3,
        ACT_DEFER,
        ACT_EL1_REG,
        ACT_EL2_REG
    } pls_act_type;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [47:0]   el1_fields_ff;
    logic [47:0]   nxt_el1_fields;
    logic [47:0]   el2_fields_ff;
    logic [47:0]   nxt_el2_fields;
    logic [1:0]    el2_traps_ff;
    logic [1:0]    nxt_el2_traps;
    logic          el2_enable_ff;
    logic          nxt_el2_enable;
    logic          enable_ff;
    logic          nxt_enable;
    pls_resp_type  resp_ff;
    pls_resp_type  nxt_resp;
    pls_label_type label_ff;
    pls_label_type nxt_label;

    logic          eff_enable;
    logic [2:0]    nv_triple;
    pls_act_type   act;
    pls_act_type   el3_trap_act;
    logic [63:0]   el1_view;
    logic [63:0]   el2_view;

    localparam logic RST_TRAP = HAS_EL3 ? RST_TRAP_WITH_EL3 : RST_TRAP_NO_EL3;

    // ------------------------------------------------------------------
    // Shared enable and register views
    // ------------------------------------------------------------------
    // One enable only: with EL3 the EL3 bit owns it, no local copy is read
    assign eff_enable = HAS_EL3 ? cfg.el3_label_enable : el2_enable_ff;
    assign nv_triple  = {cfg.nested_virt_bit2, cfg.nested_virt_bit1, cfg.nested_virt_bit};
    // Bits 62..48 of the EL1 view and 62..50 of the EL2 view read zero
    assign el1_view   = {eff_enable, 15'h0000, el1_fields_ff};
    assign el2_view   = {eff_enable, 4'h0, 9'h000, el2_traps_ff, el2_fields_ff};

    // Debug-halted cores with secure debug disabled must not enter EL3
    assign el3_trap_act = (cfg.halted && cfg.secure_debug_disable) ? ACT_UNDEF
                                                                    : ACT_TRAP_EL3;

    // ------------------------------------------------------------------
    // Decision tree per register and level
    // ------------------------------------------------------------------
    always_comb begin
        act = ACT_UNDEF;
        unique case (req.sel)
            PLS_SEL_EL1_LABEL: begin
                unique case (req.el)
                    PLS_EL0: act = ACT_UNDEF;
                    PLS_EL1: begin
                        if (HAS_EL3 && cfg.lower_level_trap) begin
                            act = el3_trap_act;
                        end else if (cfg.el2_enabled && el2_traps_ff[0]) begin
                            act = ACT_TRAP_EL2;
                        end else if (cfg.el2_enabled && nv_triple == NV_TRIPLE_EL1) begin
                            act = ACT_DEFER;
                        end else begin
                            act = ACT_EL1_REG;
                        end
                    end
                    PLS_EL2: begin
                        if (HAS_EL3 && cfg.lower_level_trap) begin
                            act = el3_trap_act;
                        end else if (cfg.host_extension_mode) begin
                            act = ACT_EL2_REG;
                        end else begin
                            act = ACT_EL1_REG;
                        end
                    end
                    PLS_EL3: act = ACT_EL1_REG;
                endcase
            end
            PLS_SEL_EL1_ALIAS_UPPER: begin
                unique case (req.el)
                    PLS_EL0: act = ACT_UNDEF;
                    PLS_EL1: begin
                        if (cfg.el2_enabled && nv_triple == NV_TRIPLE_ALIAS) begin
                            act = ACT_DEFER;
                        end else if (cfg.el2_enabled && cfg.nested_virt_bit) begin
                            if (HAS_EL3 && cfg.lower_level_trap) begin
                                act = el3_trap_act;
                            end else begin
                                act = ACT_TRAP_EL2;
                            end
                        end else begin
                            act = ACT_UNDEF;
                        end
                    end
                    PLS_EL2: begin
                        if (!cfg.host_extension_mode) begin
                            act = ACT_UNDEF;
                        end else if (HAS_EL3 && cfg.lower_level_trap) begin
                            act = el3_trap_act;
                        end else begin
                            act = ACT_EL1_REG;
                        end
                    end
                    PLS_EL3: begin
                        if (cfg.el2_enabled && cfg.el2_is_64bit && cfg.host_extension_mode) begin
                            act = ACT_EL1_REG;
                        end else begin
                            act = ACT_UNDEF;
                        end
                    end
                endcase
            end
            PLS_SEL_EL2_LABEL: begin
                unique case (req.el)
                    PLS_EL0: act = ACT_UNDEF;
                    PLS_EL1: begin
                        if (cfg.el2_enabled && cfg.nested_virt_bit) begin
                            act = (HAS_EL3 && cfg.lower_level_trap) ? el3_trap_act
                                                                    : ACT_TRAP_EL2;
                        end else begin
                            act = ACT_UNDEF;
                        end
                    end
                    PLS_EL2: begin
                        act = (HAS_EL3 && cfg.lower_level_trap) ? el3_trap_act
                                                                : ACT_EL2_REG;
                    end
                    PLS_EL3: act = ACT_EL2_REG;
                endcase
            end
            PLS_SEL_NONE: act = ACT_UNDEF;
        endcase
    end

    // ------------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------------
    // Fields and EL2 trap bits change on writes, the EL2 enable flop only without EL3; reserved bits have no flops
    always_comb begin
        nxt_el1_fields = el1_fields_ff;
        nxt_el2_fields = el2_fields_ff;
        nxt_el2_traps  = el2_traps_ff;
        nxt_el2_enable = el2_enable_ff;
        if (req.valid && req.write && act == ACT_EL1_REG) begin
            nxt_el1_fields = req.wdata[FIELD_MSB:0];
        end
        if (req.valid && req.write && act == ACT_EL2_REG) begin
            nxt_el2_fields = req.wdata[FIELD_MSB:0];
            nxt_el2_traps  = req.wdata[TRAP_EL0_BIT:TRAP_EL1_BIT];
            if (!HAS_EL3) begin
                nxt_el2_enable = req.wdata[ENABLE_BIT];
            end
        end
        nxt_enable = eff_enable;
    end

    // ------------------------------------------------------------------
    // Response next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_resp              = '0;
        nxt_resp.valid        = req.valid;
        nxt_resp.kind         = PLS_RESP_UNDEF;
        nxt_resp.defer_write  = req.write;
        unique case (act)
            ACT_UNDEF: nxt_resp.kind = PLS_RESP_UNDEF;
            ACT_TRAP_EL2: begin
                nxt_resp.kind     = PLS_RESP_TRAP_EL2;
                nxt_resp.syndrome = SYNDROME_SYSREG;
            end
            ACT_TRAP_EL3: begin
                nxt_resp.kind     = PLS_RESP_TRAP_EL3;
                nxt_resp.syndrome = SYNDROME_SYSREG;
            end
            ACT_DEFER: begin
                nxt_resp.kind         = PLS_RESP_DEFER;
                nxt_resp.defer_offset = DEFER_SLOT_OFFSET;
                nxt_resp.defer_wdata  = req.write ? req.wdata : 64'h0000_0000_0000_0000;
            end
            ACT_EL1_REG: begin
                nxt_resp.kind  = PLS_RESP_DONE;
                nxt_resp.rdata = req.write ? 64'h0000_0000_0000_0000 : el1_view;
            end
            ACT_EL2_REG: begin
                nxt_resp.kind  = PLS_RESP_DONE;
                nxt_resp.rdata = req.write ? 64'h0000_0000_0000_0000 : el2_view;
            end
        endcase
        if (!req.valid) begin
            nxt_resp = '0;
        end
    end

    // ------------------------------------------------------------------
    // Label generation for memory requests
    // ------------------------------------------------------------------
    // EL3 labels come from a register outside this block: defaults here
    always_comb begin
        nxt_label               = '0;
        nxt_label.valid         = mreq.valid;
        nxt_label.partition_id  = DEFAULT_PARTITION_ID;
        nxt_label.monitor_group = DEFAULT_PMG;
        if (mreq.valid && eff_enable) begin
            unique case (mreq.el)
                PLS_EL0, PLS_EL1: begin
                    nxt_label.partition_id  = mreq.instr
                        ? el1_fields_ff[PARTITION_ID_I_LSB +: 16]
                        : el1_fields_ff[PARTITION_ID_D_LSB +: 16];
                    nxt_label.monitor_group = mreq.instr
                        ? el1_fields_ff[PMG_I_LSB +: 8]
                        : el1_fields_ff[PMG_D_LSB +: 8];
                end
                PLS_EL2: begin
                    if (cfg.el2_enabled) begin
                        nxt_label.partition_id  = mreq.instr
                            ? el2_fields_ff[PARTITION_ID_I_LSB +: 16]
                            : el2_fields_ff[PARTITION_ID_D_LSB +: 16];
                        nxt_label.monitor_group = mreq.instr
                            ? el2_fields_ff[PMG_I_LSB +: 8]
                            : el2_fields_ff[PMG_D_LSB +: 8];
                    end
                end
                PLS_EL3: begin
                    nxt_label.partition_id  = DEFAULT_PARTITION_ID;
                    nxt_label.monitor_group = DEFAULT_PMG;
                end
            endcase
        end
        if (!mreq.valid) begin
            nxt_label = '0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Warm reset: enable cleared, identifier fields to a known zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            el1_fields_ff <= RST_FIELDS;
            el2_fields_ff <= RST_FIELDS;
            el2_traps_ff  <= {RST_TRAP, RST_TRAP};
            el2_enable_ff <= RST_ENABLE;
            enable_ff     <= RST_ENABLE;
            resp_ff       <= '0;
            label_ff      <= '0;
        end else begin
            el1_fields_ff <= nxt_el1_fields;
            el2_fields_ff <= nxt_el2_fields;
            el2_traps_ff  <= nxt_el2_traps;
            el2_enable_ff <= nxt_el2_enable;
            enable_ff     <= nxt_enable;
            resp_ff       <= nxt_resp;
            label_ff      <= nxt_label;
        end
    end

    assign resp         = resp_ff;
    assign label        = label_ff;
    assign label_enable = enable_ff;

endmodule : pls_sysreg_access

// File: pls_sysreg_access_asserts.sv
`timescale 1ns/1ps
module pls_sysreg_access_asserts #(
    parameter bit          HAS_EL3        = 1'b1,
    parameter logic [15:0] DEFAULT_PARTITION_ID = 16'h0000,
    parameter logic [7:0]  DEFAULT_PMG    = 8'h00
) (
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire pls_pkg::pls_req_type   req,
    input wire pls_pkg::pls_cfg_type   cfg,
    input wire pls_pkg::pls_mreq_type  mreq,
    input wire pls_pkg::pls_resp_type  resp,
    input wire pls_pkg::pls_label_type label,
    input wire logic                   label_enable
);
    import pls_pkg::*;
    logic [2:0] nvt;
    logic       lock;
    // Triple is nv2, nv1, nv; lock turns any EL3 trap into undefined
    assign nvt  = {cfg.nested_virt_bit2, cfg.nested_virt_bit1, cfg.nested_virt_bit};
    assign lock = cfg.halted && cfg.secure_debug_disable;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Access by select and level, and the answer kind that follows
    sequence s_acc(pls_sel_type s, pls_el_type e);
        req.valid && req.sel == s && req.el == e;
    endsequence
    sequence s_ans(pls_resp_kind_type k);
        resp.valid && resp.kind == k;
    endsequence
    a_resp_next:
        assert property (!$past(rst) |-> resp.valid == $past(req.valid))
        else $error("answer not one cycle after request");
    a_el0_undef:
        assert property (req.valid && req.el == PLS_EL0 |=> s_ans(PLS_RESP_UNDEF))
        else $error("EL0 access not undefined");
    a_alias_defer:
        assert property (s_acc(PLS_SEL_EL1_ALIAS_UPPER, PLS_EL1) ##0
            (cfg.el2_enabled && nvt == NV_TRIPLE_ALIAS) |=>
            s_ans(PLS_RESP_DEFER) ##0 resp.defer_offset == DEFER_SLOT_OFFSET)
        else $error("alias access not deferred");
    a_alias_nest:
        assert property (s_acc(PLS_SEL_EL1_ALIAS_UPPER, PLS_EL1) ##0 (HAS_EL3 &&
            cfg.el2_enabled && cfg.nested_virt_bit && nvt != NV_TRIPLE_ALIAS && !lock) |=>
            resp.kind == ($past(cfg.lower_level_trap) ? PLS_RESP_TRAP_EL3 : PLS_RESP_TRAP_EL2)
            && resp.syndrome == SYNDROME_SYSREG)
        else $error("nested alias access trap wrong");
    a_alias_undef:
        assert property (s_acc(PLS_SEL_EL1_ALIAS_UPPER, PLS_EL1) ##0
            !(cfg.el2_enabled && cfg.nested_virt_bit) |=> s_ans(PLS_RESP_UNDEF))
        else $error("plain alias access not undefined");
    a_alias_el2:
        assert property (s_acc(PLS_SEL_EL1_ALIAS_UPPER, PLS_EL2) ##0
            !cfg.host_extension_mode |=> s_ans(PLS_RESP_UNDEF))
        else $error("EL2 alias without host mode not undefined");
    a_alias_el3:
        assert property (s_acc(PLS_SEL_EL1_ALIAS_UPPER, PLS_EL3) |=> resp.kind == ($past(
            cfg.el2_enabled && cfg.el2_is_64bit && cfg.host_extension_mode)
            ? PLS_RESP_DONE : PLS_RESP_UNDEF))
        else $error("EL3 alias answer wrong");
    a_lower_trap:
        assert property (s_acc(PLS_SEL_EL1_LABEL, PLS_EL1) ##0 (HAS_EL3 &&
            cfg.lower_level_trap && !lock) |=>
            s_ans(PLS_RESP_TRAP_EL3) ##0 resp.syndrome == SYNDROME_SYSREG)
        else $error("lower level trap not taken");
    a_debug_undef:
        assert property (s_acc(PLS_SEL_EL1_LABEL, PLS_EL2) ##0 (HAS_EL3 &&
            cfg.lower_level_trap && lock) |=> s_ans(PLS_RESP_UNDEF))
        else $error("halted trap not undefined");
    a_en_mirror:
        assert property (HAS_EL3 && !$past(rst) |-> label_enable == $past(cfg.el3_label_enable))
        else $error("enable does not follow EL3 bit");
    a_reset_clear:
        assert property (disable iff (1'b0) rst |=> !label_enable && !resp.valid && !label.valid)
        else $error("reset did not clear outputs");
    a_label_dflt:
        assert property (HAS_EL3 && mreq.valid && !cfg.el3_label_enable && !label_enable |=>
            label.valid && label.partition_id == DEFAULT_PARTITION_ID
            && label.monitor_group == DEFAULT_PMG)
        else $error("disabled label not default");
    a_resv_zero:
        assert property (req.valid && req.sel == PLS_SEL_EL2_LABEL |=> resp.rdata[62:50] == 0)
        else $error("reserved bits not zero");
endmodule : pls_sysreg_access_asserts

bind pls_sysreg_access pls_sysreg_access_asserts #(
    .HAS_EL3(HAS_EL3), .DEFAULT_PARTITION_ID(DEFAULT_PARTITION_ID), .DEFAULT_PMG(DEFAULT_PMG)
) u_chk (
    .clk_sys(clk_sys), .rst(rst), .req(req), .cfg(cfg), .mreq(mreq),
    .resp(resp), .label(label), .label_enable(label_enable)
);

// File: pls_pipe_model.sv
`timescale 1ns/1ps
module pls_pipe_model (
    input  wire pls_pkg::pls_resp_type  resp,
    input  wire pls_pkg::pls_label_type label,
    input  wire logic                   clk_sys,
    output pls_pkg::pls_req_type        req,
    output pls_pkg::pls_cfg_type        cfg,
    output pls_pkg::pls_mreq_type       mreq
);
    import pls_pkg::*;
    // Quiet from time zero, nothing issued while reset is held
    initial begin
        req  = '0;
        cfg  = '0;
        mreq = '0;
    end
    // One instruction; valid left up so calls run back to back
    task automatic access(input logic wr, input pls_sel_type s, input pls_el_type e,
                          input logic [63:0] d, input pls_cfg_type c, output pls_resp_type r);
        @(negedge clk_sys);
        mreq.valid = 1'b0;
        cfg        = c;
        req        = '{1'b1, wr, s, e, d};
        @(posedge clk_sys);
        #1;
        r = resp;
    endtask : access
    // One memory request; answer is a one-cycle label
    task automatic fetch(input pls_el_type e, input logic ins, input pls_cfg_type c,
                         output pls_label_type l);
        @(negedge clk_sys);
        req.valid = 1'b0;
        cfg       = c;
        mreq      = '{1'b1, e, ins};
        @(posedge clk_sys);
        #1;
        l = label;
    endtask : fetch
    task automatic idle();
        @(negedge clk_sys);
        req.valid  = 1'b0;
        mreq.valid = 1'b0;
    endtask : idle
endmodule : pls_pipe_model

// File: tb_partition_label_sysreg_access.sv
`timescale 1ns/1ps
module tb_partition_label_sysreg_access;
    import pls_pkg::*;
    logic              clk_sys;
    logic              rst;
    pls_req_type       req;
    pls_cfg_type       cfg;
    pls_mreq_type      mreq;
    pls_resp_type      resp;
    pls_label_type     label;
    logic              label_enable;
    pls_resp_type      rsp;
    pls_label_type     lbl;
    pls_cfg_type       c;
    pls_resp_kind_type k;
    logic [63:0]       rng_state;
    logic [63:0]       val;
    logic [63:0]       r;
    int                num_errors;
    int                tests_run;

    pls_sysreg_access dut (
        .clk_sys(clk_sys), .rst(rst), .req(req), .cfg(cfg), .mreq(mreq),
        .resp(resp), .label(label), .label_enable(label_enable)
    );
    pls_pipe_model u_pipe (
        .resp(resp), .label(label), .clk_sys(clk_sys), .req(req), .cfg(cfg), .mreq(mreq)
    );

    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;

    function automatic logic [63:0] xs();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 7);
        rng_state = rng_state ^ (rng_state << 17);
        return rng_state;
    endfunction : xs

    // Expected answer kind; EL3 traps turn undefined under debug lock
    function automatic pls_resp_kind_type exp_kind(pls_sel_type s, pls_el_type e,
                                                   pls_cfg_type c, logic b48);
        pls_resp_kind_type t3;
        logic [2:0]        nvt;
        logic              en;
        t3  = (c.halted && c.secure_debug_disable) ? PLS_RESP_UNDEF : PLS_RESP_TRAP_EL3;
        nvt = {c.nested_virt_bit2, c.nested_virt_bit1, c.nested_virt_bit};
        en  = c.el2_enabled;
        if (e == PLS_EL0 || s == PLS_SEL_NONE) return PLS_RESP_UNDEF;
        if (s == PLS_SEL_EL1_ALIAS_UPPER && e == PLS_EL3)
            return (en && c.el2_is_64bit && c.host_extension_mode) ? PLS_RESP_DONE
                                                                    : PLS_RESP_UNDEF;
        if (s == PLS_SEL_EL1_ALIAS_UPPER && e == PLS_EL2 && !c.host_extension_mode)
            return PLS_RESP_UNDEF;
        if (e == PLS_EL3) return PLS_RESP_DONE;
        if (s != PLS_SEL_EL1_LABEL && e == PLS_EL1) begin
            if (s == PLS_SEL_EL1_ALIAS_UPPER && en && nvt == NV_TRIPLE_ALIAS)
                return PLS_RESP_DEFER;
            if (!(en && c.nested_virt_bit)) return PLS_RESP_UNDEF;
            return c.lower_level_trap ? t3 : PLS_RESP_TRAP_EL2;
        end
        if (c.lower_level_trap) return t3;
        if (e == PLS_EL2) return PLS_RESP_DONE;
        if (en && b48) return PLS_RESP_TRAP_EL2;
        return (en && nvt == NV_TRIPLE_EL1) ? PLS_RESP_DEFER : PLS_RESP_DONE;
    endfunction : exp_kind

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic end_sim();
        $display("counts: tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Watchdog, well past the roughly 2020 cycles the run needs
    initial begin
        repeat (10000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end

    initial begin
        clk_sys    = 1'b0;
        rst        = 1'b1;
        num_errors = 0;
        tests_run  = 0;
        rng_state  = 64'h0000_0000_0000_003B;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check({label_enable, resp.valid}, 0);
        $display("test reset done");
        c                  = '0;
        c.el3_label_enable = 1'b1;
        val                = xs();
        u_pipe.access(1'b1, PLS_SEL_EL1_LABEL, PLS_EL1, val, c, rsp);
        check(rsp.kind, PLS_RESP_DONE);
        u_pipe.access(1'b0, PLS_SEL_EL1_LABEL, PLS_EL1, ~val, c, rsp);
        check(rsp.rdata, {1'b1, 15'h0000, val[47:0]});
        check(label_enable, 1'b1);
        $display("test el1 write readback done");
        // Reserved bits and trap bit 48 set; EL3 enable low
        c.el3_label_enable = 1'b0;
        val                = xs() | 64'h7FFD_0000_0000_0000;
        u_pipe.access(1'b1, PLS_SEL_EL2_LABEL, PLS_EL2, val, c, rsp);
        u_pipe.access(1'b0, PLS_SEL_EL2_LABEL, PLS_EL2, ~val, c, rsp);
        check(rsp.rdata, {14'h0000, val[49:0]});
        c.el2_enabled = 1'b1;
        {c.nested_virt_bit2, c.nested_virt_bit1, c.nested_virt_bit} = NV_TRIPLE_EL1;
        u_pipe.access(1'b0, PLS_SEL_EL1_LABEL, PLS_EL1, val, c, rsp);
        check({rsp.kind, rsp.syndrome}, {PLS_RESP_TRAP_EL2, SYNDROME_SYSREG});
        val[48] = 1'b0;
        u_pipe.access(1'b1, PLS_SEL_EL2_LABEL, PLS_EL2, val, c, rsp);
        u_pipe.access(1'b0, PLS_SEL_EL1_LABEL, PLS_EL1, val, c, rsp);
        check({rsp.kind, rsp.defer_offset}, {PLS_RESP_DEFER, DEFER_SLOT_OFFSET});
        c.nested_virt_bit1 = 1'b0;
        u_pipe.access(1'b1, PLS_SEL_EL1_ALIAS_UPPER, PLS_EL1, val, c, rsp);
        check({rsp.kind, rsp.defer_write}, {PLS_RESP_DEFER, 1'b1});
        check(rsp.defer_wdata, val);
        $display("test traps and deferral done");
        c.el3_label_enable = 1'b1;
        u_pipe.fetch(PLS_EL2, 1'b0, c, lbl);
        check({lbl.partition_id, lbl.monitor_group}, {val[31:16], val[47:40]});
        u_pipe.fetch(PLS_EL2, 1'b1, c, lbl);
        check({lbl.partition_id, lbl.monitor_group}, {val[15:0], val[39:32]});
        c.el3_label_enable = 1'b0;
        for (int i = 0; i < 2; i++) begin
            u_pipe.fetch(PLS_EL2, i[0], c, lbl);
            check({lbl.valid, lbl.partition_id, lbl.monitor_group}, 25'h100_0000);
        end
        // Enable high but EL2 disabled: EL2 register must not label
        c.el3_label_enable = 1'b1;
        c.el2_enabled      = 1'b0;
        u_pipe.fetch(PLS_EL2, 1'b0, c, lbl);
        check({lbl.valid, lbl.partition_id, lbl.monitor_group}, 25'h100_0000);
        $display("test labels done");
        // Random reads over 2000 random select, level and control mixes
        for (int i = 0; i < 2000; i++) begin
            r = xs();
            c = pls_cfg_type'(r[9:0]);
            u_pipe.access(1'b0, pls_sel_type'(r[11:10]), pls_el_type'(r[13:12]), r, c, rsp);
            k   = exp_kind(pls_sel_type'(r[11:10]), pls_el_type'(r[13:12]), c, 1'b0);
            val = (k == PLS_RESP_TRAP_EL2 || k == PLS_RESP_TRAP_EL3) ? 64'(SYNDROME_SYSREG) : '0;
            check(rsp.kind, k);
            check(rsp.syndrome, val);
        end
        u_pipe.idle();
        $display("test random decode done");
        end_sim();
    end
endmodule : tb_partition_label_sysreg_access
